// file: rtl/backlight_control_status_regs.v
// host-visible control and status registers of a multi-string
// LED backlight driver, reached over SMBus/I2C pins
// assumes fault detectors are asynchronous levels; the channel
// logic gates its readback with light_on_o
`timescale 1ns/10ps
`include "backlight_regs_consts.vh"

// Notes on behaviour
// (R01) switch on: mode bits 00 combined, 01 pin PWM, 10 host, 11 keep.
// (R02) writing switch bit 0 turns the light off at once.
// (R03) writing switch bit 1 turns the light on within 4 ms.
// (R04) on shows status bit 3 high; off shows it low.
// (R05) control bits 7..3 read back as written, reset to zero.
// (R06) PWM level register returns last host write in combined mode.
// (R07) control register resets to 0x00, light off.
// (R08) status bit 0 is OR of the four fault conditions only.
// (R09) status bit 4 set while one or more strings are down.
// (R10) status bit 5 set while two or more strings are down.
// (R11) bit 2 follows excess current, bit 1 follows thermal trip.
// (R12) fault bit sticky; cleared by switch toggle or writing zero.
// (R13) no fault reported for an on command quickly followed by off.
// (R14) status read-only except bit 0; bits 7 and 6 read zero.
// (R15) status register resets to 0x00.
// (R16) id register: bit 7 one, maker code 6..3, revision 2..0.
// (R17) maker codes 10..14 reserved, 15 means no maker code.
// (R18) revision starts at zero, steps by one per shipped revision.
// (R19) DC level sets current in 256 linear steps, live.
// (R20) write to 0x07 changes only DC level; read returns it.
// (R21) DC level resets to 0xFF.
// (R22) every register one byte, Read Byte and Write Byte only.
// (R23) bus address bytes 0x58 for write, 0x59 for read.
// (R24) fault detector inputs synchronised before updating flags.
module backlight_control_status_regs #(
  parameter [31:0] ON_CYCLES  = `LIGHT_ON_CYCLES,
  parameter [3:0]  MAKER_CODE = 4'hF, // arbitrary neutral value
  parameter [2:0]  SI_REV     = 3'h0,
  parameter        STRINGS    = 6
) (
  // clock and reset
  input  wire               clk_i,
  input  wire               rstn_i,
  // bus pins
  input  wire               scl_i,
  input  wire               sda_i,
  output wire               sda_o,
  output wire               sda_oe_o,
  // fault detectors
  input  wire               thermal_trip_i,
  input  wire               input_excess_amps_i,
  input  wire [STRINGS-1:0] string_down_i,
  // to the power stage
  output reg                light_on_o,
  output reg  [1:0]         dim_mode_o,
  output reg  [7:0]         pwm_level_o,
  output reg  [7:0]         dc_level_o
);

  localparam [2:0] L_OFF  = 3'h1;
  localparam [2:0] L_RAMP = 3'h2;
  localparam [2:0] L_ON   = 3'h4;

  // population count of down strings
  function [3:0] count_down;
    input [STRINGS-1:0] v;
    integer k;
    begin
      count_down = 4'h0;
      for (k = 0; k < STRINGS; k = k + 1) begin
        count_down = count_down + {3'h0, v[k]};
      end
    end
  endfunction

  // write strobe aimed at one offset
  function hit;
    input       strobe;
    input [7:0] ptr;
    input [7:0] ofs;
    begin
      hit = strobe && ptr == ofs;
    end
  endfunction

  // status byte; reserved bits 7 and 6 stay zero
  function [7:0] pack_status;
    input fault;
    input thermal;
    input excess;
    input lit;
    input one_down;
    input two_down;
    begin
      pack_status                    = 8'h00;
      pack_status[`STS_FAULT_BIT]    = fault;
      pack_status[`STS_THERMAL_BIT]  = thermal;
      pack_status[`STS_EXCESS_BIT]   = excess;
      pack_status[`STS_STATE_BIT]    = lit;
      pack_status[`STS_ONE_DOWN_BIT] = one_down;
      pack_status[`STS_TWO_DOWN_BIT] = two_down;
    end
  endfunction

  wire [7:0] reg_ptr;
  wire       wr;
  wire [7:0] wr_data;
  reg  [7:0] rd_data;

  reg  [7:0]         mode_control;
  reg                fault_sticky;
  reg  [2:0]         lstate;
  reg  [31:0]        on_cnt;
  reg  [1:0]         thermal_s;
  reg  [1:0]         excess_s;
  reg  [STRINGS-1:0] down_s1;
  reg  [STRINGS-1:0] down_s2;
  reg                thermal_flag;
  reg                excess_flag;
  reg                one_down_flag;
  reg                two_down_flag;
  reg                next_fault;
  reg                any_fault;

  // bus engine: one byte access at a time, no buffering
  smbus_byte_slave u_slave (
    .clk_i     (clk_i),
    .rstn_i    (rstn_i),
    .scl_i     (scl_i),
    .sda_i     (sda_i),
    .sda_o     (sda_o),
    .sda_oe_o  (sda_oe_o),
    .reg_ptr_o (reg_ptr),
    .wr_o      (wr),
    .wr_data_o (wr_data),
    .rd_data_i (rd_data)
  );

  // one-cycle write strobes per register
  wire wr_ctl  = hit(wr, reg_ptr, `OFS_MODE_CONTROL);
  wire wr_sts  = hit(wr, reg_ptr, `OFS_FAULT_FLAGS);
  wire wr_pwm  = hit(wr, reg_ptr, `OFS_PWM_LEVEL);
  wire wr_dc   = hit(wr, reg_ptr, `OFS_DC_LEVEL);
  wire sw_new  = wr_data[`CTL_SWITCH_BIT];
  wire sw_old  = mode_control[`CTL_SWITCH_BIT];
  wire [1:0] mode_new = wr_data[`CTL_MODE_MSB:`CTL_MODE_LSB];

  // two-flop synchronisers for the fault detectors
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_s <= 2'h0;
      excess_s  <= 2'h0;
      down_s1   <= {STRINGS{1'b0}};
      down_s2   <= {STRINGS{1'b0}};
    end else begin
      thermal_s <= {thermal_s[0], thermal_trip_i};     // R24
      excess_s  <= {excess_s[0], input_excess_amps_i}; // R24
      down_s1   <= string_down_i;                      // R24
      down_s2   <= down_s1;
    end
  end

  // status flags; a read sees one settled byte
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      thermal_flag  <= 1'b0;
      excess_flag   <= 1'b0;
      one_down_flag <= 1'b0;
      two_down_flag <= 1'b0;
    end else begin
      thermal_flag  <= thermal_s[1];                // R11
      excess_flag   <= excess_s[1];                 // R11
      one_down_flag <= count_down(down_s2) >= 4'h1; // R09
      two_down_flag <= count_down(down_s2) >= 4'h2; // R10
    end
  end

  // any fault condition; the light state is not one
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      any_fault <= 1'b0;
    end else begin
      any_fault <= thermal_flag | excess_flag |
                   one_down_flag | two_down_flag; // R08
    end
  end

  // control register and effective dimming mode
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mode_control <= `RST_MODE_CONTROL; // R07
      dim_mode_o   <= `RST_DIM_MODE;
    end else if (wr_ctl) begin
      mode_control <= wr_data; // R05
      if (sw_new && mode_new != `MODE_KEEP) begin
        dim_mode_o <= mode_new; // R01
      end
    end
  end

  // PWM level; host writes dropped while the pin sets dimming
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pwm_level_o <= `RST_PWM_LEVEL;
    end else if (wr_pwm && dim_mode_o != `MODE_PIN_PWM) begin
      pwm_level_o <= wr_data; // R06
    end
  end

  // DC level, taken live while the outputs run
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      dc_level_o <= `RST_DC_LEVEL; // R21
    end else if (wr_dc) begin
      dc_level_o <= wr_data; // R19 R20
    end
  end

  // light on/off sequencing
  // an off write wins over any ramp in progress; an on write
  // while already on leaves the light on without a new ramp
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lstate     <= L_OFF;
      on_cnt     <= 32'h0;
      light_on_o <= 1'b0;
    end else if (wr_ctl && !sw_new) begin
      lstate     <= L_OFF; // R02
      on_cnt     <= 32'h0;
      light_on_o <= 1'b0;
    end else begin
      case (lstate)
        L_OFF: begin
          if (wr_ctl && sw_new) begin
            lstate <= L_RAMP;
            on_cnt <= 32'h0;
          end
        end
        L_RAMP: begin
          if (on_cnt + 32'h1 >= ON_CYCLES) begin
            lstate     <= L_ON; // R03
            light_on_o <= 1'b1;
          end else begin
            on_cnt <= on_cnt + 32'h1;
          end
        end
        L_ON: begin
          light_on_o <= 1'b1;
        end
        default: begin
          lstate     <= L_OFF;
          light_on_o <= 1'b0;
        end
      endcase
    end
  end

  // sticky fault summary; a new fault wins over a clear
  always @* begin
    next_fault = fault_sticky;
    if ((wr_ctl && sw_new != sw_old) ||
        (wr_sts && !wr_data[`STS_FAULT_BIT])) begin
      next_fault = 1'b0; // R12
    end
    // gated by the light so a quick on/off reports nothing
    if (light_on_o && any_fault) begin
      next_fault = 1'b1; // R08 R13
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      fault_sticky <= 1'b0; // R15
    end else begin
      fault_sticky <= next_fault;
    end
  end

  // read data for the addressed register
  always @* begin
    rd_data = 8'h00;
    case (reg_ptr)
      `OFS_PWM_LEVEL: begin
        rd_data = pwm_level_o;
      end
      `OFS_MODE_CONTROL: begin
        rd_data = mode_control; // R05
      end
      `OFS_FAULT_FLAGS: begin
        rd_data = pack_status(fault_sticky, thermal_flag, excess_flag,
                              light_on_o, one_down_flag,
                              two_down_flag); // R04 R14
      end
      `OFS_MAKER_REV_ID: begin
        rd_data = {`ID_PANEL_BIT, MAKER_CODE, SI_REV}; // R16 R17 R18
      end
      `OFS_DC_LEVEL: begin
        rd_data = dc_level_o; // R20
      end
      default: begin
        rd_data = 8'h00;
      end
    endcase
  end

endmodule

// file: rtl/backlight_regs_consts.vh
// constants for the backlight control and status register bank
// assumes a 10 MHz register clock and an SMBus/I2C host on the pins
`ifndef BACKLIGHT_REGS_CONSTS_VH
`define BACKLIGHT_REGS_CONSTS_VH

// register offsets (command byte values)
`define OFS_PWM_LEVEL      8'h00
`define OFS_MODE_CONTROL   8'h01
`define OFS_FAULT_FLAGS    8'h02
`define OFS_MAKER_REV_ID   8'h03
`define OFS_DC_LEVEL       8'h07

// reset values
`define RST_PWM_LEVEL      8'hFF
`define RST_MODE_CONTROL   8'h00
`define RST_FAULT_FLAGS    8'h00
`define RST_DC_LEVEL       8'hFF
`define RST_DIM_MODE       2'h0

// control register fields
`define CTL_SWITCH_BIT     0
`define CTL_MODE_LSB       1
`define CTL_MODE_MSB       2

// status register fields
`define STS_FAULT_BIT      0
`define STS_THERMAL_BIT    1
`define STS_EXCESS_BIT     2
`define STS_STATE_BIT      3
`define STS_ONE_DOWN_BIT   4
`define STS_TWO_DOWN_BIT   5

// dimming modes as {dimming_mode_bit, origin choice}
`define MODE_COMBINED      2'h0
`define MODE_PIN_PWM       2'h1
`define MODE_HOST_PWM      2'h2
`define MODE_KEEP          2'h3

// identification register
`define ID_PANEL_BIT       1'h1

// bus device address, 7-bit form of write byte 0x58 / read byte 0x59
`define BUS_DEV_ADDR       7'h2C

// timing
`define CLK_HZ             10000000
`define LIGHT_ON_MAX_US    4000
`define LIGHT_ON_CYCLES    ((`LIGHT_ON_MAX_US) * ((`CLK_HZ) / 1000000))

`endif

// file: rtl/smbus_byte_slave.v
// SMBus/I2C slave engine for Read Byte and Write Byte transactions
// assumes scl and sda are open-drain wires seen through pins, slow
// against clk_i; sda pulled low when sda_oe_o is high
`timescale 1ns/10ps
`include "backlight_regs_consts.vh"

module smbus_byte_slave (
  // clock and reset
  input  wire       clk_i,
  input  wire       rstn_i,
  // bus pins
  input  wire       scl_i,
  input  wire       sda_i,
  output reg        sda_o,
  output reg        sda_oe_o,
  // register side
  output reg  [7:0] reg_ptr_o,
  output reg        wr_o,
  output reg  [7:0] wr_data_o,
  input  wire [7:0] rd_data_i
);

  localparam [4:0] S_IDLE = 5'h01;
  localparam [4:0] S_RX   = 5'h02;
  localparam [4:0] S_ACK  = 5'h04;
  localparam [4:0] S_TX   = 5'h08;
  localparam [4:0] S_RACK = 5'h10;

  reg [4:0] state;
  reg [2:0] scl_s;
  reg [2:0] sda_s;
  reg [3:0] bitcnt;
  reg [7:0] shreg;
  reg [1:0] byte_no;
  reg       is_read;

  wire scl_rise = scl_s[1] & ~scl_s[2];
  wire scl_fall = ~scl_s[1] & scl_s[2];
  wire sda_now  = sda_s[1];
  wire start_c  = scl_s[1] & scl_s[2] & ~sda_s[1] & sda_s[2];
  wire stop_c   = scl_s[1] & scl_s[2] & sda_s[1] & ~sda_s[2];

  // two flops per pin, third stage only for edge finding
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      scl_s <= 3'h7;
      sda_s <= 3'h7;
    end else begin
      scl_s <= {scl_s[1:0], scl_i};
      sda_s <= {sda_s[1:0], sda_i};
    end
  end

  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state     <= S_IDLE;
      sda_o     <= 1'b0;
      sda_oe_o  <= 1'b0;
      bitcnt    <= 4'h0;
      shreg     <= 8'h00;
      byte_no   <= 2'h0;
      is_read   <= 1'b0;
      reg_ptr_o <= 8'h00;
      wr_o      <= 1'b0;
      wr_data_o <= 8'h00;
    end else begin
      wr_o <= 1'b0;
      if (stop_c) begin
        state    <= S_IDLE;
        sda_oe_o <= 1'b0;
      end else if (start_c) begin
        state    <= S_RX;
        sda_oe_o <= 1'b0;
        bitcnt   <= 4'h0;
        byte_no  <= 2'h0;
      end else begin
        case (state)
          S_IDLE: begin
            sda_oe_o <= 1'b0;
          end
          S_RX: begin
            if (scl_rise && bitcnt != 4'h8) begin
              shreg  <= {shreg[6:0], sda_now};
              bitcnt <= bitcnt + 4'h1;
            end else if (scl_fall && bitcnt == 4'h8) begin
              if (byte_no == 2'h0) begin
                if (shreg[7:1] == `BUS_DEV_ADDR) begin // R23
                  is_read  <= shreg[0];
                  sda_oe_o <= 1'b1;
                  state    <= S_ACK;
                end else begin
                  state <= S_IDLE;
                end
              end else begin
                if (byte_no == 2'h1) begin
                  reg_ptr_o <= shreg;
                end else begin
                  wr_o      <= 1'b1; // R22
                  wr_data_o <= shreg;
                end
                sda_oe_o <= 1'b1;
                state    <= S_ACK;
              end
            end
          end
          S_ACK: begin
            if (scl_fall) begin
              bitcnt <= 4'h0;
              if (is_read && byte_no == 2'h0) begin
                shreg    <= rd_data_i;
                sda_oe_o <= ~rd_data_i[7];
                state    <= S_TX;
              end else begin
                sda_oe_o <= 1'b0;
                state    <= S_RX;
                if (byte_no != 2'h2) begin
                  byte_no <= byte_no + 2'h1;
                end
              end
            end
          end
          S_TX: begin
            if (scl_fall) begin
              if (bitcnt == 4'h7) begin
                sda_oe_o <= 1'b0;
                state    <= S_RACK;
              end else begin
                shreg    <= {shreg[6:0], 1'b0};
                sda_oe_o <= ~shreg[6];
                bitcnt   <= bitcnt + 4'h1;
              end
            end
          end
          S_RACK: begin
            if (scl_rise && sda_now) begin
              state <= S_IDLE;
            end else if (scl_fall) begin
              bitcnt   <= 4'h0;
              shreg    <= rd_data_i;
              sda_oe_o <= ~rd_data_i[7];
              state    <= S_TX;
            end
          end
          default: begin
            state    <= S_IDLE;
            sda_oe_o <= 1'b0;
          end
        endcase
      end
    end
  end

endmodule

// file: testbench/backlight_regs_chk.sv
// assertions on the backlight register bank top ports
// assumes one register clock domain with async active-low reset
`timescale 1ns/10ps
module backlight_regs_chk #(
  parameter [31:0] ON_CYCLES = 32'd40000
) (
  input wire       clk_i,
  input wire       rstn_i,
  input wire       scl_i,
  input wire       sda_o,
  input wire       sda_oe_o,
  input wire       light_on_o,
  input wire [1:0] dim_mode_o,
  input wire [7:0] pwm_level_o,
  input wire [7:0] dc_level_o
);
  reg [31:0] since_ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  // cycles since the bank last pulled SDA
  always @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i)
      since_ack <= 32'h0;
    else if (sda_oe_o)
      since_ack <= 32'h0;
    else if (since_ack != 32'hFFFFFFFF)
      since_ack <= since_ack + 32'h1;
  end

  a_reset_vals: assert property ($rose(rstn_i) |->
    dc_level_o == 8'hFF && !light_on_o && dim_mode_o == 2'h0)
    else $error("bad values after reset");
  a_mode_legal: assert property (dim_mode_o != 2'h3)
    else $error("keep code reached mode output");
  a_mode_at_write: assert property ($changed(dim_mode_o) |->
    sda_oe_o || $past(sda_oe_o))
    else $error("mode changed outside a write");
  a_light_bound: assert property ($rose(light_on_o) |->
    since_ack <= ON_CYCLES && since_ack + 32'd24 >= ON_CYCLES)
    else $error("light on at wrong delay");
  a_light_off_now: assert property ($fell(light_on_o) |->
    sda_oe_o || $past(sda_oe_o))
    else $error("light off outside a write");
  a_dc_only: assert property ($changed(dc_level_o) |->
    $stable(pwm_level_o) && $stable(dim_mode_o))
    else $error("dc write touched other fields");
  a_pwm_write: assert property ($changed(pwm_level_o) |->
    dim_mode_o != 2'h1 && (sda_oe_o || $past(sda_oe_o)))
    else $error("pwm level changed unexpectedly");
  a_sda_value: assert property (!sda_o)
    else $error("sda data value not low");
  a_oe_hold: assert property (scl_i && $past(scl_i) |->
    $stable(sda_oe_o))
    else $error("sda moved while scl high");

  c_light_on: cover property ($rose(light_on_o));
  c_host_mode: cover property (dim_mode_o == 2'h2);
  c_dc_write: cover property ($changed(dc_level_o));
endmodule

bind backlight_control_status_regs backlight_regs_chk #(
  .ON_CYCLES(ON_CYCLES)
) u_chk (
  .clk_i      (clk_i),
  .rstn_i     (rstn_i),
  .scl_i      (scl_i),
  .sda_o      (sda_o),
  .sda_oe_o   (sda_oe_o),
  .light_on_o (light_on_o),
  .dim_mode_o (dim_mode_o),
  .pwm_level_o(pwm_level_o),
  .dc_level_o (dc_level_o)
);

// file: testbench/smbus_host_model.sv
// SMBus host model issuing Write Byte and Read Byte frames
// assumes the bench resolves open-drain SDA with a pull-up
`timescale 1ns/10ps
module smbus_host_model (
  // clock
  input  wire clk_i,
  // bus pins
  input  wire sda_i,
  output reg  scl_o,
  output reg  sda_low_o
);
  reg junk;

  // idle bus: SCL stands high, SDA released
  initial begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end

  task hc(input integer n);
    repeat (n) @(posedge clk_i);
  endtask

  // one 8-clock SCL period; sample late in the high phase
  task bit_x(input b, output r);
    begin
      scl_o <= 1'b0;
      hc(2);
      sda_low_o <= ~b;
      hc(2);
      scl_o <= 1'b1;
      hc(4);
      r = sda_i;
    end
  endtask

  task byte_x(input [7:0] d, input m, output [7:0] r, output nk);
    integer i;
    begin
      for (i = 7; i >= 0; i = i - 1)
        bit_x(d[i], r[i]);
      bit_x(m, nk);
    end
  endtask

  task start_c;
    begin
      bit_x(1'b1, junk);
      sda_low_o <= 1'b1;
      hc(4);
    end
  endtask

  task stop_c;
    begin
      bit_x(1'b0, junk);
      sda_low_o <= 1'b0;
      hc(4);
    end
  endtask

  // nk is high if any acknowledge slot was missed
  task write_reg(input [7:0] dev, input [7:0] ofs, input [7:0] d,
                 output nk);
    reg [7:0] r;
    reg       a;
    reg       b;
    reg       c;
    begin
      start_c;
      byte_x(dev, 1'b1, r, a);
      byte_x(ofs, 1'b1, r, b);
      byte_x(d, 1'b1, r, c);
      stop_c;
      nk = a | b | c;
    end
  endtask

  task read_reg(input [7:0] ofs, output [7:0] d, output nk);
    reg [7:0] r;
    reg       a;
    reg       b;
    reg       c;
    begin
      start_c;
      byte_x(8'h58, 1'b1, r, a);
      byte_x(ofs, 1'b1, r, b);
      start_c;
      byte_x(8'h59, 1'b1, r, c);
      byte_x(8'hFF, 1'b1, d, junk);
      stop_c;
      nk = a | b | c;
    end
  endtask
endmodule

// file: testbench/test_backlight_control_status_regs.sv
// self-checking bench for the backlight register bank
// assumes smbus_host_model drives the pins, SDA pulled up
`timescale 1ns/10ps
module test_backlight_control_status_regs;
  localparam [31:0] ON_CYC = 32'd400;
  reg        clk = 1'b0;
  reg        rstn = 1'b0;
  reg        therm = 1'b0;
  reg        excess = 1'b0;
  reg  [5:0] down = 6'h00;
  wire       scl;
  wire       sda_low;
  wire       sda_oe;
  wire       light;
  wire [1:0] mode;
  wire [7:0] pwm;
  wire [7:0] dc;
  wire       sda = ~(sda_low | sda_oe);
  reg  [7:0] got;
  reg        nk;
  integer    miscompares = 0;
  integer    check_count = 0;
  integer    i;
  integer    n;

  always #50 clk = ~clk;

  backlight_control_status_regs #(
    .ON_CYCLES (ON_CYC),
    .MAKER_CODE(4'hF),
    .SI_REV    (3'h0),
    .STRINGS   (6)
  ) u_dut (
    .clk_i              (clk),
    .rstn_i             (rstn),
    .scl_i              (scl),
    .sda_i              (sda),
    .sda_o              (),
    .sda_oe_o           (sda_oe),
    .thermal_trip_i     (therm),
    .input_excess_amps_i(excess),
    .string_down_i      (down),
    .light_on_o         (light),
    .dim_mode_o         (mode),
    .pwm_level_o        (pwm),
    .dc_level_o         (dc)
  );

  smbus_host_model u_host (
    .clk_i    (clk),
    .sda_i    (sda),
    .scl_o    (scl),
    .sda_low_o(sda_low)
  );

  task chk(input [7:0] g, input [7:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        miscompares = miscompares + 1;
        $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask

  task rd(input [7:0] a, input [7:0] e);
    begin
      u_host.read_reg(a, got, nk);
      chk({7'h0, nk}, 8'h00);
      chk(got, e);
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      u_host.write_reg(8'h58, a, d, nk);
      chk({7'h0, nk}, 8'h00);
    end
  endtask

  task wait_on;
    begin
      n = 0;
      while (light !== 1'b1 && n < ON_CYC + 50) begin
        @(posedge clk);
        n = n + 1;
      end
      chk({7'h0, light}, 8'h01);
    end
  endtask

  task wrap_up;
    begin
      if (miscompares == 0 && check_count > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask

  initial begin
    repeat (60000) @(posedge clk);
    miscompares = miscompares + 1;
    wrap_up;
  end

  initial begin
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    rd(8'h07, 8'hFF);
    rd(8'h03, 8'hF8);
    wr(8'h03, 8'h00);
    rd(8'h03, 8'hF8);
    wr(8'h05, 8'h12);
    rd(8'h05, 8'h00);
    u_host.write_reg(8'h5A, 8'h07, 8'h00, nk);
    chk({7'h0, nk}, 8'h01);
    rd(8'h07, 8'hFF);
    wr(8'h07, 8'h00);
    chk(dc, 8'h00);
    wr(8'h07, 8'h5A);
    rd(8'h07, 8'h5A);
    chk(pwm, 8'hFF);
    wr(8'h01, 8'hF8);
    rd(8'h01, 8'hF8);
    chk({7'h0, light}, 8'h00);
    for (i = 0; i < 4; i = i + 1) begin
      wr(8'h01, {5'h0, i[1:0], 1'b1});
      wait_on;
      chk({6'h0, mode}, (i == 3) ? 8'h02 : i[7:0]);
      rd(8'h02, 8'h08);
      wr(8'h01, 8'h00);
      chk({7'h0, light}, 8'h00);
      rd(8'h02, 8'h00);
    end
    wr(8'h01, 8'h01);
    wait_on;
    wr(8'h00, 8'h3C);
    rd(8'h00, 8'h3C);
    chk(pwm, 8'h3C);
    wr(8'h01, 8'h03);
    chk({6'h0, mode}, 8'h01);
    wr(8'h00, 8'h77);
    rd(8'h00, 8'h3C);
    wr(8'h01, 8'h01);
    down <= 6'h01;
    rd(8'h02, 8'h19);
    down <= 6'h05;
    rd(8'h02, 8'h39);
    down <= 6'h00;
    rd(8'h02, 8'h09);
    therm <= 1'b1;
    rd(8'h02, 8'h0B);
    therm <= 1'b0;
    excess <= 1'b1;
    rd(8'h02, 8'h0D);
    excess <= 1'b0;
    wr(8'h02, 8'hFF);
    rd(8'h02, 8'h09);
    wr(8'h02, 8'hF0);
    rd(8'h02, 8'h08);
    down <= 6'h01;
    rd(8'h02, 8'h19);
    down <= 6'h00;
    wr(8'h01, 8'h00);
    rd(8'h02, 8'h00);
    down <= 6'h01;
    wr(8'h01, 8'h01);
    wr(8'h01, 8'h00);
    rd(8'h02, 8'h10);
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (4) @(posedge clk);
    rd(8'h07, 8'hFF);
    rd(8'h01, 8'h00);
    wrap_up;
  end
endmodule
